// *** hdl/ead_pkg.sv ***
// Purpose: Shared constants and types for the effective-address decoder.
// Assumes: 32-bit AXI4-Lite register port, 16-bit extension word stream.
// Notes:   Offsets are byte addresses within the register window.
package ead_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] EAD_CTRL_OFF = 8'h00;
  localparam logic [7:0] EAD_STATUS_OFF = 8'h04;
  localparam logic [7:0] EAD_COUNT_OFF = 8'h08;
  localparam logic EAD_CTRL_ENABLE_RST = 1'b1;
  localparam logic [1:0] EAD_RESP_OKAY = 2'h0;
  localparam logic [1:0] EAD_RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Instruction encodings
  // ****************************************************************
  localparam logic [2:0] EAD_M_DREG = 3'h0;
  localparam logic [2:0] EAD_M_AREG = 3'h1;
  localparam logic [2:0] EAD_M_IND = 3'h2;
  localparam logic [2:0] EAD_M_PREDEC = 3'h4;
  localparam logic [2:0] EAD_M_D16 = 3'h5;
  localparam logic [2:0] EAD_M_IDX = 3'h6;
  localparam logic [2:0] EAD_M_EXT = 3'h7;
  localparam logic [2:0] EAD_R_ABSW = 3'h0;
  localparam logic [2:0] EAD_R_ABSL = 3'h1;
  localparam logic [2:0] EAD_R_PCD16 = 3'h2;
  localparam logic [2:0] EAD_R_PCIDX = 3'h3;
  localparam logic [2:0] EAD_R_IMM = 3'h4;
  localparam logic [1:0] EAD_SZ_BYTE = 2'h0;
  localparam logic [1:0] EAD_SZ_LONG = 2'h2;
  localparam logic [7:0] EAD_MAX_EXT = 8'h0A;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    EAD_IDLE = 3'b000,
    EAD_FIRST = 3'b001,
    EAD_BD = 3'b010,
    EAD_OD = 3'b011,
    EAD_LIT = 3'b100,
    EAD_FIN = 3'b101
  } ead_state_e;
  typedef enum logic [1:0] {
    EAD_LIT_IMM = 2'b00,
    EAD_LIT_D16 = 2'b01,
    EAD_LIT_ABS = 2'b10
  } ead_lit_e;
  typedef enum logic [1:0] {
    EAD_IND_NONE = 2'b00,
    EAD_IND_PRE = 2'b01,
    EAD_IND_POST = 2'b10,
    EAD_IND_MEM = 2'b11
  } ead_ind_e;
endpackage : ead_pkg

// *** hdl/ead_decoder.sv ***
// What this block does
// - Byte immediate low byte, word immediate whole.
// - Long immediate: first word high, second low.
// - Mode 111 register 100 means immediate.
// - Coprocessor immediates take any word count.
// - Mode selects; register sub-selects under 111.
// - Support up to ten extension words.
// - Indirect select decode with index enabled.
// - Indirect select decode with index suppressed.
// - Brief word fields when bit 8 clear.
// - Full word fields when bit 8 set.
// - Index kind and index size selection.
// - Base suppress forces base contribution zero.
// - Index suppress forces index contribution zero.
// - Base displacement size decode, 00 reserved.
// - Consume base then outer displacement words.
// - Mode codes 000 through 110 decode.
// - Register codes under mode 111 decode.
// - Alterable flag excludes PC and immediate.
// - Control flag for memory modes without size.
// - Data and memory flags, each combined with alterable by AND.
// - Scale shifts index left zero to three.
// - Indirect forms reported on indir_kind; no pointer is fetched.
// - Absolute short sign-extended to 32 bits.
// Purpose: Decodes one effective address and its extension words.
// Assumes: Prefetch inputs are on aclk; one address decoded at a time.
// Notes:   Coprocessor immediates longer than 32 bits keep only the last 32.
`timescale 1ns/1ps
module ead_decoder (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Instruction request
  input wire logic ea_start,
  input wire logic [2:0] ea_mode,
  input wire logic [2:0] ea_reg,
  input wire logic [1:0] op_size,
  input wire logic coproc_imm,
  input wire logic [7:0] coproc_words,
  output logic ea_busy,
  // Extension word stream
  input wire logic ext_valid,
  input wire logic [15:0] ext_word,
  output logic ext_ready,
  // Register values from the datapath
  input wire logic [31:0] base_val,
  input wire logic [31:0] index_val,
  // Decode results
  output logic ea_done,
  output logic ea_illegal,
  output logic [7:0] ext_count,
  output logic cat_data,
  output logic cat_mem,
  output logic cat_ctrl,
  output logic cat_alt,
  output logic cat_alt_mem,
  output logic cat_data_alt,
  output logic [31:0] imm_data,
  output logic [31:0] abs_addr,
  output logic [31:0] base_disp,
  output logic [31:0] outer_disp,
  output logic index_reg_kind,
  output logic [2:0] index_reg_n,
  output logic index_size_sel,
  output logic [1:0] scale,
  output logic base_suppress_bit,
  output logic index_suppress_bit,
  output ead_pkg::ead_ind_e indir_kind,
  output logic [31:0] base_term,
  output logic [31:0] index_term
);
  import ead_pkg::*;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic [31:0] sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction : sext16

  // Words that a two-bit size field asks for; 00 gives none.
  function automatic logic [1:0] size_words(input logic [1:0] f);
    size_words = (f == 2'b00) ? 2'd0 : f - 2'd1;
  endfunction : size_words

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    ead_state_e st;
    ead_lit_e lit;
    logic [7:0] left;
    logic [1:0] bdn;
    logic [1:0] odn;
    logic [31:0] acc;
    logic [31:0] bacc;
    logic [31:0] oacc;
    logic [2:0] mode;
    logic [2:0] rg;
    logic [1:0] size;
    logic coproc;
    logic bad;
    logic [7:0] cnt;
    logic ext_ready;
    logic done;
    logic illegal;
    logic [7:0] ext_count;
    logic [5:0] cats;
    logic [31:0] imm_data;
    logic [31:0] abs_addr;
    logic [31:0] base_disp;
    logic [31:0] outer_disp;
    logic idx_kind;
    logic [2:0] idx_n;
    logic idx_long;
    logic [1:0] scale;
    logic bs;
    logic is;
    ead_ind_e ind;
    logic [31:0] base_term;
    logic [31:0] index_term;
    logic enable;
    logic [15:0] total;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ead_regs_s;

  ead_regs_s q_reg;
  ead_regs_s q_next;
  logic take;

  assign take = ext_valid && q_reg.ext_ready;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // One process covers the decoder, the datapath terms and the bus slave.
  always_comb begin
    logic [15:0] w;
    logic [31:0] idx;
    w = ext_word;
    idx = q_reg.idx_long ? index_val : sext16(index_val[15:0]);
    q_next = q_reg;
    q_next.done = 1'b0;
    if (take) begin
      q_next.cnt = q_reg.cnt + 8'd1;
    end
    case (q_reg.st)
      EAD_IDLE: begin
        if (ea_start && q_reg.enable) begin
          q_next.mode = ea_mode;
          q_next.rg = ea_reg;
          q_next.size = op_size;
          q_next.coproc = coproc_imm;
          q_next.cnt = 8'd0;
          q_next.bad = 1'b0;
          q_next.acc = 32'h0000_0000;
          q_next.bacc = 32'h0000_0000;
          q_next.oacc = 32'h0000_0000;
          q_next.bdn = 2'd0;
          q_next.odn = 2'd0;
          q_next.bs = 1'b0;
          q_next.is = 1'b1;
          q_next.ind = EAD_IND_NONE;
          q_next.left = 8'd1;
          // Cleared so that a displacement form decoded earlier cannot leak into base_disp.
          q_next.lit = EAD_LIT_IMM;
          q_next.st = EAD_LIT;
          // Mode picks the form; register field only sub-selects under 111.
          if (ea_mode <= EAD_M_PREDEC) begin
            q_next.st = EAD_FIN;
          end else if (ea_mode == EAD_M_D16) begin
            q_next.lit = EAD_LIT_D16;
          end else if (ea_mode == EAD_M_IDX) begin
            q_next.st = EAD_FIRST;
          end else if (ea_reg == EAD_R_ABSW) begin
            q_next.lit = EAD_LIT_ABS;
          end else if (ea_reg == EAD_R_ABSL) begin
            q_next.lit = EAD_LIT_ABS;
            q_next.left = 8'd2;
          end else if (ea_reg == EAD_R_PCD16) begin
            q_next.lit = EAD_LIT_D16;
          end else if (ea_reg == EAD_R_PCIDX) begin
            q_next.st = EAD_FIRST;
          end else if (ea_reg == EAD_R_IMM) begin
            q_next.lit = EAD_LIT_IMM;
            // Coprocessor immediates carry their own length.
            if (coproc_imm) begin
              q_next.left = coproc_words;
              if (coproc_words == 8'd0) begin
                q_next.st = EAD_FIN;
              end
            end else if (op_size == EAD_SZ_LONG) begin
              q_next.left = 8'd2;
            end
          end else begin
            q_next.bad = 1'b1;
            q_next.st = EAD_FIN;
          end
        end
      end
      EAD_FIRST: begin
        if (take) begin
          q_next.idx_kind = w[15];
          q_next.idx_n = w[14:12];
          q_next.idx_long = w[11];
          q_next.scale = w[10:9];
          q_next.is = 1'b0;
          if (!w[8]) begin
            // Brief word: 8-bit displacement handled like a long base value.
            q_next.bacc = {{24{w[7]}}, w[7:0]};
            q_next.bdn = 2'd2;
            q_next.st = EAD_FIN;
          end else begin
            q_next.bs = w[7];
            q_next.is = w[6];
            q_next.bdn = size_words(w[5:4]);
            q_next.odn = size_words(w[1:0]);
            if (w[2:0] == 3'b000) begin
              q_next.ind = EAD_IND_NONE;
            end else if (w[6]) begin
              q_next.ind = EAD_IND_MEM;
            end else if (w[2]) begin
              q_next.ind = EAD_IND_POST;
            end else begin
              q_next.ind = EAD_IND_PRE;
            end
            // Reserved encodings are flagged and consume no outer words.
            if ((w[5:4] == 2'b00) || w[3] || (w[2:0] == 3'b100) || (w[6] && w[2])) begin
              q_next.bad = 1'b1;
              q_next.odn = 2'd0;
              q_next.ind = EAD_IND_NONE;
            end
            q_next.left = {6'd0, q_next.bdn};
            if (q_next.bdn != 2'd0) begin
              q_next.st = EAD_BD;
            end else if (q_next.odn != 2'd0) begin
              q_next.left = {6'd0, q_next.odn};
              q_next.st = EAD_OD;
            end else begin
              q_next.st = EAD_FIN;
            end
          end
        end
      end
      EAD_BD: begin
        if (take) begin
          q_next.bacc = {q_reg.bacc[15:0], w};
          q_next.left = q_reg.left - 8'd1;
          if (q_reg.left == 8'd1) begin
            q_next.left = {6'd0, q_reg.odn};
            q_next.st = (q_reg.odn != 2'd0) ? EAD_OD : EAD_FIN;
          end
        end
      end
      EAD_OD: begin
        if (take) begin
          q_next.oacc = {q_reg.oacc[15:0], w};
          q_next.left = q_reg.left - 8'd1;
          if (q_reg.left == 8'd1) begin
            q_next.st = EAD_FIN;
          end
        end
      end
      EAD_LIT: begin
        if (take) begin
          // High word arrives first, so shifting up leaves it on top.
          q_next.acc = {q_reg.acc[15:0], w};
          q_next.left = q_reg.left - 8'd1;
          if (q_reg.left == 8'd1) begin
            q_next.st = EAD_FIN;
          end
        end
      end
      EAD_FIN: begin
        q_next.done = 1'b1;
        q_next.illegal = q_reg.bad;
        q_next.ext_count = q_reg.cnt;
        q_next.total = q_reg.total + 16'd1;
        q_next.base_disp = (q_reg.bdn == 2'd1) ? sext16(q_reg.bacc[15:0]) : q_reg.bacc;
        q_next.outer_disp = (q_reg.odn == 2'd1) ? sext16(q_reg.oacc[15:0]) : q_reg.oacc;
        q_next.imm_data = 32'h0000_0000;
        q_next.abs_addr = 32'h0000_0000;
        if (q_reg.lit == EAD_LIT_D16 && q_reg.mode >= EAD_M_D16) begin
          q_next.base_disp = sext16(q_reg.acc[15:0]);
        end
        if (q_reg.mode == EAD_M_EXT && q_reg.rg == EAD_R_IMM) begin
          if (q_reg.size == EAD_SZ_BYTE && !q_reg.coproc) begin
            q_next.imm_data = {24'h00_0000, q_reg.acc[7:0]};
          end else begin
            q_next.imm_data = q_reg.acc;
          end
        end
        if (q_reg.mode == EAD_M_EXT && q_reg.rg == EAD_R_ABSW) begin
          q_next.abs_addr = sext16(q_reg.acc[15:0]);
        end else if (q_reg.mode == EAD_M_EXT && q_reg.rg == EAD_R_ABSL) begin
          q_next.abs_addr = q_reg.acc;
        end
        // Categories: {data, mem, ctrl, alt, alt_mem, data_alt}.
        q_next.cats[5] = (q_reg.mode != EAD_M_AREG);
        q_next.cats[4] = (q_reg.mode >= EAD_M_IND);
        q_next.cats[3] = (q_reg.mode == EAD_M_IND) || (q_reg.mode >= EAD_M_D16 &&
                         !(q_reg.mode == EAD_M_EXT && q_reg.rg >= EAD_R_IMM));
        q_next.cats[2] = (q_reg.mode != EAD_M_EXT) || (q_reg.rg <= EAD_R_ABSL);
        if (q_reg.bad) begin
          q_next.cats[5:2] = 4'h0;
        end
        q_next.cats[1] = q_next.cats[2] && q_next.cats[4];
        q_next.cats[0] = q_next.cats[5] && q_next.cats[2];
        q_next.st = EAD_IDLE;
      end
      default: begin
        q_next.st = EAD_IDLE;
      end
    endcase
    q_next.ext_ready = (q_next.st == EAD_FIRST) || (q_next.st == EAD_BD) ||
                       (q_next.st == EAD_OD) || (q_next.st == EAD_LIT);

    // Address terms for the datapath; the index register itself is untouched.
    q_next.index_term = q_reg.is ? 32'h0000_0000 : (idx << q_reg.scale);
    q_next.base_term = q_reg.bs ? 32'h0000_0000 : base_val;

    // Write path: address and data are taken in either order.
    if (s_axi_awvalid && q_reg.awready) begin
      q_next.aw_got = 1'b1;
      q_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q_reg.wready) begin
      q_next.w_got = 1'b1;
      q_next.wdata = s_axi_wdata;
      q_next.wstrb0 = s_axi_wstrb[0];
    end
    if (q_reg.bvalid && s_axi_bready) begin
      q_next.bvalid = 1'b0;
    end
    if (q_reg.aw_got && q_reg.w_got && !q_reg.bvalid) begin
      q_next.aw_got = 1'b0;
      q_next.w_got = 1'b0;
      q_next.bvalid = 1'b1;
      q_next.bresp = EAD_RESP_OKAY;
      if (q_reg.awaddr == EAD_CTRL_OFF) begin
        if (q_reg.wstrb0) begin
          q_next.enable = q_reg.wdata[0];
        end
      end else if (q_reg.awaddr == EAD_STATUS_OFF || q_reg.awaddr == EAD_COUNT_OFF) begin
        q_next.bresp = EAD_RESP_OKAY;
      end else begin
        q_next.bresp = EAD_RESP_SLVERR;
      end
    end
    q_next.awready = !q_next.aw_got && !q_next.bvalid;
    q_next.wready = !q_next.w_got && !q_next.bvalid;

    // Read path: one outstanding read, answered one cycle after address.
    if (q_reg.rvalid && s_axi_rready) begin
      q_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q_reg.arready) begin
      q_next.rvalid = 1'b1;
      q_next.rresp = EAD_RESP_OKAY;
      q_next.rdata = 32'h0000_0000;
      if (s_axi_araddr == EAD_CTRL_OFF) begin
        q_next.rdata = {31'h0, q_reg.enable};
      end else if (s_axi_araddr == EAD_STATUS_OFF) begin
        q_next.rdata = {16'h0000, q_reg.ext_count, 6'h00, q_reg.illegal,
                        (q_reg.st != EAD_IDLE)};
      end else if (s_axi_araddr == EAD_COUNT_OFF) begin
        q_next.rdata = {16'h0000, q_reg.total};
      end else begin
        q_next.rresp = EAD_RESP_SLVERR;
      end
    end
    q_next.arready = !q_next.rvalid;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Synchronous reset; every field takes a constant.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_reg <= '0;
      q_reg.st <= EAD_IDLE;
      q_reg.is <= 1'b1;
      q_reg.enable <= EAD_CTRL_ENABLE_RST;
    end else begin
      q_reg <= q_next;
    end
  end

  // Outputs come straight from the state register; ea_busy is decoded from its state field.
  assign s_axi_awready = q_reg.awready;
  assign s_axi_wready = q_reg.wready;
  assign s_axi_bvalid = q_reg.bvalid;
  assign s_axi_bresp = q_reg.bresp;
  assign s_axi_arready = q_reg.arready;
  assign s_axi_rvalid = q_reg.rvalid;
  assign s_axi_rdata = q_reg.rdata;
  assign s_axi_rresp = q_reg.rresp;
  assign ea_busy = (q_reg.st != EAD_IDLE);
  assign ext_ready = q_reg.ext_ready;
  assign ea_done = q_reg.done;
  assign ea_illegal = q_reg.illegal;
  assign ext_count = q_reg.ext_count;
  assign {cat_data, cat_mem, cat_ctrl, cat_alt, cat_alt_mem, cat_data_alt} = q_reg.cats;
  assign imm_data = q_reg.imm_data;
  assign abs_addr = q_reg.abs_addr;
  assign base_disp = q_reg.base_disp;
  assign outer_disp = q_reg.outer_disp;
  assign index_reg_kind = q_reg.idx_kind;
  assign index_reg_n = q_reg.idx_n;
  assign index_size_sel = q_reg.idx_long;
  assign scale = q_reg.scale;
  assign base_suppress_bit = q_reg.bs;
  assign index_suppress_bit = q_reg.is;
  assign indir_kind = q_reg.ind;
  assign base_term = q_reg.base_term;
  assign index_term = q_reg.index_term;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_imm_detect: assert property (q_reg.st == EAD_IDLE && ea_start && q_reg.enable &&
      ea_mode == 3'h7 && ea_reg == 3'h4 && !coproc_imm |=> q_reg.st == EAD_LIT)
    else $error("immediate mode not recognised");
  a_imm_byte: assert property (ea_done && q_reg.mode == 3'h7 && q_reg.rg == 3'h4 &&
      q_reg.size == 2'h0 && !q_reg.coproc |-> imm_data[31:8] == 24'h0)
    else $error("byte immediate not masked");
  a_imm_order: assert property (take && q_reg.st == EAD_LIT && q_reg.left == 8'd1 &&
      q_reg.lit == EAD_LIT_IMM && q_reg.size == 2'h2 && !q_reg.coproc
      |-> ##2 imm_data == {$past(q_reg.acc[15:0], 2), $past(ext_word, 2)})
    else $error("long immediate word order wrong");
  a_ext_limit: assert property (ea_done && !q_reg.coproc |-> ext_count <= 8'd10)
    else $error("too many extension words");
  a_brief_fields: assert property (take && q_reg.st == EAD_FIRST && !ext_word[8]
      |=> index_reg_n == $past(ext_word[14:12]) && scale == $past(ext_word[10:9]) ##1
      ea_done && base_disp == {{24{$past(ext_word[7], 2)}}, $past(ext_word[7:0], 2)})
    else $error("brief word decoded wrongly");
  a_bd_reserved: assert property (take && q_reg.st == EAD_FIRST && ext_word[8] &&
      ext_word[5:4] == 2'b00 |-> ##[1:12] ea_done && ea_illegal)
    else $error("reserved base size not flagged");
  a_pc_not_alt: assert property (ea_done && q_reg.mode == 3'h7 && q_reg.rg >= 3'h2 |->
      !cat_alt && !cat_alt_mem)
    else $error("PC or immediate flagged alterable");
  a_base_zero: assert property (base_suppress_bit |=> base_term == 32'h0)
    else $error("suppressed base leaked");
  a_ready_drop: assert property (ea_done |-> !ext_ready)
    else $error("stream still ready after done");

  c_brief: cover property (take && q_reg.st == EAD_FIRST && !ext_word[8] ##2 ea_done);
  c_full_od: cover property (q_reg.st == EAD_OD ##[1:4] ea_done && outer_disp != 32'h0);
  c_imm_long: cover property (ea_done && q_reg.size == 2'h2 && q_reg.rg == 3'h4);
  c_coproc: cover property (ea_done && q_reg.coproc && ext_count > 8'd2);
endmodule : ead_decoder

// *** tb/ead_ext_src.sv ***
// Purpose: Prefetch stream model that feeds extension words.
// Assumes: The bench queues words before each decode.
// Notes: While idle the data line inverts itself on every cycle.
`timescale 1ns/1ps
module ead_ext_src (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Stream
  input wire logic slow,
  input wire logic ext_ready,
  output logic ext_valid,
  output logic [15:0] ext_word
);
  logic [15:0] q [$];
  logic tick = 1'h0;
  initial ext_valid = 1'h0;
  initial ext_word = 16'h0000;
  task automatic push(input logic [15:0] w);
    q.push_back(w);
  endtask : push
  // A word is held until taken; slow mode offers one only every other cycle.
  always @(posedge aclk) begin
    tick <= ~tick;
    if (!aresetn) begin
      ext_valid <= 1'h0;
    end else if (!(ext_valid && !ext_ready)) begin
      if (ext_valid) void'(q.pop_front());
      if (q.size() > 0 && !(slow && tick)) begin
        ext_valid <= 1'h1;
        ext_word <= q[0];
      end else begin
        ext_valid <= 1'h0;
        ext_word <= ~ext_word;
      end
    end
  end
endmodule : ead_ext_src

// *** tb/tb.sv ***
// Purpose: Self-checking bench for the effective-address decoder.
// Assumes: The stream model supplies extension words in order.
// Notes: Category flags are worked out from the mode tables.
`timescale 1ns/1ps
module tb;
  import ead_pkg::*;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, coproc_words, ext_count;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, imm_data, abs_addr, base_disp, outer_disp;
  logic [31:0] base_term, index_term, rd, base_val, index_val;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0, ea_start = 1'h0, coproc_imm, slow = 1'h0, ext_valid, ext_ready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ea_busy, ea_done;
  logic ea_illegal, cat_data, cat_mem, cat_ctrl, cat_alt, cat_alt_mem, cat_data_alt, d, me, c, a;
  logic index_reg_kind, index_size_sel, base_suppress_bit, index_suppress_bit;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, scale, op_size = 2'h0;
  logic [2:0] ea_mode = 3'h0, ea_reg = 3'h0, index_reg_n, m, r;
  logic [15:0] ext_word;
  logic [15:0] bad [4] = '{16'h0154, 16'h0114, 16'h0118, 16'h0100};
  ead_ind_e indir_kind;
  int errors = 0;
  int compares = 0;
  wire [5:0] cats = {cat_data, cat_mem, cat_ctrl, cat_alt, cat_alt_mem, cat_data_alt};
  // Both sides connect by matching names.
  ead_decoder i_ead_decoder (.*);
  ead_ext_src i_ead_ext_src (.*);
  // Core clock, 8 ns period.
  initial forever #4 aclk = ~aclk;
  task end_sim;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // A wait that outlives its bound counts as a mismatch and ends the run.
  task tmo(inout int n);
    n++;
    if (n > 300) begin
      errors++;
      end_sim();
    end
  endtask : tmo
  task automatic axw(input logic [7:0] ad, input logic [31:0] dt, input logic [3:0] st);
    int n = 0;
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      tmo(n);
      // Each channel drops its valid at the edge that takes it.
      s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
      s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
    end while (s_axi_bvalid !== 1'h1);
    rr = s_axi_bresp;
    s_axi_bready <= 1'h0;
    // An idle edge keeps the next call from raising bready in this time step.
    @(posedge aclk);
  endtask : axw
  task automatic axr(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    int n = 0;
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      tmo(n);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    dt = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask : axr
  task automatic dec(input logic [2:0] mo, input logic [2:0] rg, input logic [1:0] sz,
                     input logic cp = 1'h0, input logic [7:0] cw = 8'h00);
    int n = 0;
    ea_mode <= mo;
    ea_reg <= rg;
    op_size <= sz;
    coproc_imm <= cp;
    coproc_words <= cw;
    ea_start <= 1'h1;
    @(posedge aclk);
    ea_start <= 1'h0;
    do begin
      @(posedge aclk);
      tmo(n);
    end while (ea_done !== 1'h1);
  endtask : dec
  // Register values that the datapath offers for the address terms.
  task dp(input logic [31:0] b, input logic [31:0] x);
    base_val <= b;
    index_val <= x;
  endtask : dp
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    dp(32'h00C0FFEE, 32'h00018002);
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    axr(EAD_CTRL_OFF, rd, rr);
    chk(rd[0], EAD_CTRL_ENABLE_RST);
    axr(8'h0C, rd, rr);
    chk(rr, EAD_RESP_SLVERR);
    // Every mode, and register codes 000 through 100 under 111; long fetches must keep the high word first.
    for (int i = 0; i < 12; i++) begin
      m = (i < 7) ? i[2:0] : 3'h7;
      r = (i < 7) ? 3'h0 : i[2:0] - 3'h7;
      d = (m != 3'h1);
      me = (m > 3'h1);
      c = (m == 3'h2) || (m == 3'h5) || (m == 3'h6) || (m == 3'h7 && r < 3'h4);
      a = (m != 3'h7) || (r < 3'h2);
      if (m > 3'h4) i_ead_ext_src.push(16'hB2FE);
      if (m == 3'h7 && r == 3'h1) i_ead_ext_src.push(16'h1234);
      dec(m, r, EAD_SZ_BYTE);
      chk(cats, {d, me, c, a, a & me, d & a});
      chk(ext_count, (m < 3'h5) ? 0 : (m == 3'h7 && r == 3'h1) ? 2 : 1);
      if (i == 6) chk({index_reg_kind, index_reg_n, index_size_sel, scale, base_disp[15:0]}, 23'h59FFFE);
      if (i == 6) chk(index_term, 32'hFFFF0004);
      if (i == 7) chk(abs_addr, 32'hFFFFB2FE);
      if (i == 8) chk(abs_addr, 32'hB2FE1234);
      if (i == 11) chk(imm_data[7:0], 8'hFE);
    end
    i_ead_ext_src.push(16'hB2FE);
    dec(EAD_M_EXT, EAD_R_IMM, 2'h1);
    chk(imm_data[15:0], 16'hB2FE);
    i_ead_ext_src.push(16'hB2FE);
    i_ead_ext_src.push(16'h1234);
    dec(EAD_M_EXT, EAD_R_IMM, EAD_SZ_LONG);
    chk(imm_data, 32'hB2FE1234);
    // Full format words over a stalling stream.
    slow <= 1'h1;
    i_ead_ext_src.push(16'h5FB6);
    i_ead_ext_src.push(16'h1234);
    i_ead_ext_src.push(16'h5678);
    i_ead_ext_src.push(16'h8001);
    dec(EAD_M_IDX, 3'h0, EAD_SZ_BYTE);
    chk(base_disp, 32'h12345678);
    chk(outer_disp, 32'hFFFF8001);
    chk({ea_illegal, indir_kind, base_suppress_bit, index_reg_n, ext_count}, 15'h2D04);
    chk(base_term, 32'h0);
    chk(index_term, 32'h000C0010);
    i_ead_ext_src.push(16'h0163);
    i_ead_ext_src.push(16'h0010);
    i_ead_ext_src.push(16'hABCD);
    i_ead_ext_src.push(16'h0001);
    dec(EAD_M_IDX, 3'h0, EAD_SZ_BYTE);
    chk({ea_illegal, indir_kind, index_suppress_bit, ext_count}, 12'h704);
    chk(outer_disp, 32'hABCD0001);
    chk(index_term, 32'h0);
    chk(base_term, base_val);
    for (int k = 0; k < 4; k++) begin
      i_ead_ext_src.push(bad[k]);
      dec(EAD_M_IDX, 3'h0, EAD_SZ_BYTE);
      chk({ea_illegal, ext_count}, 9'h101);
    end
    slow <= 1'h0;
    // Unused register code 101 under mode 111 takes no words and clears every category.
    dec(EAD_M_EXT, 3'h5, EAD_SZ_BYTE);
    chk({ea_illegal, ext_count, cats}, 15'h4000);
    // Coprocessor immediate at the ten-word limit.
    for (int k = 0; k < 10; k++) i_ead_ext_src.push(16'h1000 + k[15:0]);
    dec(EAD_M_EXT, EAD_R_IMM, EAD_SZ_LONG, 1'h1, EAD_MAX_EXT);
    chk(ext_count, 8'h0A);
    chk(imm_data, 32'h10081009);
    axr(EAD_STATUS_OFF, rd, rr);
    chk(rd, 32'h00000A00);
    axr(EAD_COUNT_OFF, rd, rr);
    chk(rd, 32'h00000016);
    // A start while disabled must be ignored; a write without byte 0 changes nothing.
    axw(EAD_CTRL_OFF, 32'h0, 4'hF);
    chk(rr, EAD_RESP_OKAY);
    axw(EAD_CTRL_OFF, 32'h1, 4'h0);
    axr(EAD_CTRL_OFF, rd, rr);
    chk(rd, 32'h0);
    ea_start <= 1'h1;
    @(posedge aclk);
    ea_start <= 1'h0;
    repeat (2) @(posedge aclk);
    chk(ea_busy, 1'h0);
    axw(8'h0C, 32'h1, 4'hF);
    chk(rr, EAD_RESP_SLVERR);
    axw(EAD_CTRL_OFF, 32'h1, 4'hF);
    end_sim();
  end
endmodule : tb
